// ===== serial_tx_pkg.sv
package serial_tx_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] status_off    = 8'h00;  // serial_status_reg
  localparam logic [7:0] ctrl_b_off    = 8'h04;  // serial_control_reg_b
  localparam logic [7:0] ctrl_c_off    = 8'h08;  // serial_control_reg_c
  localparam logic [7:0] data_off      = 8'h0c;  // serial_data_reg
  localparam logic [7:0] divisor_off   = 8'h10;  // baud_divisor
  // status register fields
  localparam int st_double_speed_pos   = 1;
  localparam int st_tx_complete_pos    = 6;
  localparam int st_buf_empty_pos      = 5;
  // control b fields
  localparam int cb_ninth_pos          = 0;
  localparam int cb_char_size_hi_pos   = 2;
  localparam int cb_tx_enable_pos      = 3;
  localparam int cb_empty_ie_pos       = 5;
  localparam int cb_complete_ie_pos    = 6;
  // control c fields
  localparam int cc_polarity_pos       = 0;
  localparam int cc_char_size_lo_pos   = 1;
  localparam int cc_stop_bits_pos      = 3;
  localparam int cc_parity_odd_pos     = 4;
  localparam int cc_parity_upper_pos   = 5;
  localparam int cc_sync_mode_pos      = 6;
  localparam int cc_sync_master_pos    = 7;
  // reset values
  localparam logic [7:0] ctrl_b_rst    = 8'h00;
  localparam logic [7:0] ctrl_c_rst    = 8'h06;  // 8 data bits, no parity, 1 stop
  localparam logic [11:0] divisor_rst  = 12'h000;
  // bit-time divide ratios in baud ticks
  localparam logic [4:0] div_normal    = 5'h10;
  localparam logic [4:0] div_double    = 5'h08;
  localparam logic [4:0] div_sync      = 5'h02;
  // character size code for nine bits
  localparam logic [2:0] char_size_nine = 3'h7;
  // transmitter states
  typedef enum logic [4:0] {
    st_idle   = 5'b00001,
    st_start  = 5'b00010,
    st_data   = 5'b00100,
    st_parity = 5'b01000,
    st_stop   = 5'b10000
  } tx_state_t;
endpackage

// ===== serial_tx.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// (RQ1) parity is xor of data, inverted if odd
// (RQ2) parity bit sits between data and stop
// (RQ3) enable hands output pin to transmitter
// (RQ4) sync mode takes over the clock pin
// (RQ5) software configures format before first send
// (RQ6) data register write loads buffer, starts send
// (RQ7) buffer moves to shifter when idle or after stop
// (RQ8) frame sent at divisor, double speed, or xck rate
// (RQ9) upper data bits ignored below eight bits
// (RQ10) nine-bit mode sends ninth control bit
// (RQ11) ninth bit usable as address marker
// (RQ12) empty flag high while buffer empty
// (RQ13) software writes empty flag bit as zero
// (RQ14) empty interrupt is a level while flag high
// (RQ15) data write clears empty flag
// (RQ16) complete flag set when frame done, buffer empty
// (RQ17) complete flag cleared on ack or write one
// (RQ18) software idles transmitter before format changes
// (RQ19) low start, lsb first, high stop, idle high
// (RQ20) tick divided by 16, 8 or 2
// (RQ21) sync data changes on edge chosen by polarity
// (RQ22) parity active when upper mode bit set
// (RQ23) one or two stop bits, idle high
// (RQ24) complete irq while flag and enable; ack clears
module serial_tx
  import serial_tx_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_out,            // general port value for the pin
  output logic             serial_out_pin,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  output logic             empty_irq,
  output logic             complete_irq,
  input  wire logic        complete_irq_ack
);
  import serial_tx_pkg::*;

  // reset release through two flops
  // only rst_sync_b reaches the rest of the block, so every flop leaves reset together
  logic rst_meta;
  logic rst_sync_b;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // software visible state
  logic [7:0]  ctrl_b;              // serial_control_reg_b
  logic [7:0]  ctrl_c;              // serial_control_reg_c
  logic [11:0] baud_divisor;        // baud generator reload
  logic        double_speed_bit;    // halves the bit time in asynchronous mode
  logic        tx_complete_flag;    // frame gone, nothing pending
  logic [8:0]  tx_buffer;           // one-deep holding buffer
  logic        buffer_full;         // buffer holds unsent data

  // apb decode, single-cycle answer
  // no wait states: every register is a flop, so reads settle within the access cycle
  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire hit_st   = paddr == status_off;
  wire hit_b    = paddr == ctrl_b_off;
  wire hit_c    = paddr == ctrl_c_off;
  wire hit_data = paddr == data_off;
  wire hit_div  = paddr == divisor_off;
  wire mapped   = hit_st || hit_b || hit_c || hit_data || hit_div;
  wire data_wr  = wr && hit_data;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;   // unmapped offsets answer with an error

  // control fields
  wire       transmitter_enable_bit    = ctrl_b[cb_tx_enable_pos];
  wire       tx_ninth_bit              = ctrl_b[cb_ninth_pos];
  wire       tx_buffer_empty_irq_enable = ctrl_b[cb_empty_ie_pos];
  wire       complete_ie               = ctrl_b[cb_complete_ie_pos];
  wire [2:0] char_size_field = {ctrl_b[cb_char_size_hi_pos], ctrl_c[cc_char_size_lo_pos +: 2]};
  wire       stop_bits_select          = ctrl_c[cc_stop_bits_pos];
  wire       parity_mode_upper_bit     = ctrl_c[cc_parity_upper_pos];
  wire       parity_odd                = ctrl_c[cc_parity_odd_pos];
  wire       clock_polarity_bit        = ctrl_c[cc_polarity_pos];
  wire       sync_mode                 = ctrl_c[cc_sync_mode_pos];
  wire       sync_master               = ctrl_c[cc_sync_master_pos];
  wire       tx_buffer_empty_flag      = !buffer_full;             // RQ12

  // number of data bits for a size code; reserved codes fall back to eight
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    case (code)
      3'h0: data_bits = 4'h5;
      3'h1: data_bits = 4'h6;
      3'h2: data_bits = 4'h7;
      3'h7: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

  // mask off data bits above the character width
  function automatic logic [8:0] mask_char(input logic [8:0] d, input logic [3:0] n);
    mask_char = d & ((9'h001 << n) - 9'h001);
  endfunction

  // transmitter datapath state
  // limitation: a format change in mid-frame corrupts that frame, so software idles first
  tx_state_t   state;
  tx_state_t   next_state;
  logic [8:0]  shifter;          // frame data, lsb out first
  logic [3:0]  bit_cnt;          // bits left in current phase
  logic        parity_acc;       // parity of loaded character
  logic [11:0] baud_cnt;         // baud generator down-counter
  logic [4:0]  tick_cnt;         // baud ticks within a bit
  logic        xck_q1;           // clock pin synchroniser stage one
  logic        xck_q2;           // clock pin synchroniser stage two
  logic        xck_q3;           // previous synchronised level
  logic        master_clk;       // driven clock in synchronous master mode
  logic        tx_line;          // registered line level

  wire [3:0] nbits    = data_bits(char_size_field);
  wire       busy     = state != st_idle;
  // sync slave with cleared enable must still let a frame finish
  // trade-off: the pin stays owned while anything is pending, so disabling never cuts a frame
  wire       drive_pin = transmitter_enable_bit || busy || buffer_full;   // RQ3

  // baud tick: sys_clk / (divisor + 1)
  // the counter runs in every mode; in slave mode only the pin edges pace the bits
  wire baud_tick = baud_cnt == 12'h000;
  wire [4:0] ratio = sync_mode ? div_sync : (double_speed_bit ? div_double : div_normal);  // RQ20
  wire int_bit = baud_tick && (tick_cnt == ratio - 5'h01);
  // data changes on the rising edge with polarity zero, falling edge otherwise
  wire xck_change_edge = clock_polarity_bit ? (xck_q3 && !xck_q2) : (!xck_q3 && xck_q2);  // RQ21
  wire master_edge = clock_polarity_bit ? (baud_tick && master_clk) :
                                          (baud_tick && !master_clk);
  wire bit_strobe = sync_mode ? (sync_master ? master_edge : xck_change_edge)
                              : int_bit;                                   // RQ8
  wire last_stop  = state == st_stop && bit_cnt == 4'h1;
  wire frame_end  = bit_strobe && last_stop;
  // buffer may move when idle or right as the last stop bit ends; either way only on a
  // strobe, since a load between strobes would leave a short start bit that the far
  // receiver's mid-bit sampling cannot follow
  wire load_shift = buffer_full && bit_strobe && (state == st_idle || last_stop);  // RQ7

  // baud generator and clock pin sampling
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      baud_cnt   <= 12'h000;
      tick_cnt   <= 5'h00;
      master_clk <= 1'b0;
      xck_q1     <= 1'b0;
      xck_q2     <= 1'b0;
      xck_q3     <= 1'b0;
    end else begin
      // a divisor write reloads the counter at once, with the value being written
      if (wr && hit_div) begin
        baud_cnt <= pwdata[11:0];
      end else begin
        baud_cnt <= baud_tick ? baud_divisor : baud_cnt - 12'h001;
      end
      // tick_cnt wraps at the ratio, so a mode change in mid-bit cannot overrun it
      tick_cnt   <= baud_tick ? ((tick_cnt >= ratio - 5'h01) ? 5'h00 : tick_cnt + 5'h01)
                              : tick_cnt;
      master_clk <= (sync_mode && sync_master && baud_tick) ? !master_clk : master_clk;
      // only xck_q2 reads the first stage; q2 and q3 form the edge detector
      xck_q1     <= serial_clock_pin_in;   // RQ4
      xck_q2     <= xck_q1;
      xck_q3     <= xck_q2;
    end
  end

  // frame sequencer next state
  // states only move on strobes, so a slow divisor just stretches each one
  always_comb begin
    next_state = state;
    case (state)
      st_idle:   next_state = load_shift ? st_start : st_idle;
      st_start:  next_state = bit_strobe ? st_data : st_start;
      st_data:   if (bit_strobe && bit_cnt == 4'h1) begin
                   next_state = parity_mode_upper_bit ? st_parity : st_stop;  // RQ2 RQ22
                 end
      st_parity: next_state = bit_strobe ? st_stop : st_parity;
      st_stop:   if (frame_end) begin
                   next_state = load_shift ? st_start : st_idle;               // RQ7
                 end
      default:   next_state = st_idle;
    endcase
  end

  // frame sequencer and shifter
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state      <= st_idle;
      shifter    <= 9'h000;
      bit_cnt    <= 4'h0;
      parity_acc <= 1'b0;
      tx_line    <= 1'b1;
    end else begin
      state <= next_state;
      if (load_shift) begin
        shifter    <= tx_buffer;
        parity_acc <= ^tx_buffer ^ parity_odd;                                 // RQ1
        tx_line    <= 1'b0;                                                    // RQ19
      end else if (bit_strobe) begin
        case (state)
          st_start: begin
            tx_line <= shifter[0];                                             // RQ19
            shifter <= {1'b0, shifter[8:1]};
            bit_cnt <= nbits;
          end
          st_data: begin
            if (bit_cnt == 4'h1) begin
              tx_line <= parity_mode_upper_bit ? parity_acc : 1'b1;            // RQ2
              bit_cnt <= stop_bits_select ? 4'h2 : 4'h1;                       // RQ23
            end else begin
              tx_line <= shifter[0];
              shifter <= {1'b0, shifter[8:1]};
              bit_cnt <= bit_cnt - 4'h1;
            end
          end
          st_parity: tx_line <= 1'b1;
          st_stop: begin
            tx_line <= 1'b1;                                                   // RQ23
            bit_cnt <= bit_cnt - 4'h1;
          end
          default: tx_line <= 1'b1;
        endcase
      end
    end
  end

  // registers, buffer and flags
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_b           <= ctrl_b_rst;
      ctrl_c           <= ctrl_c_rst;
      baud_divisor     <= divisor_rst;
      double_speed_bit <= 1'b0;
      tx_complete_flag <= 1'b0;
      tx_buffer        <= 9'h000;
      buffer_full      <= 1'b0;
    end else begin
      if (wr && hit_b) ctrl_b <= pwdata[7:0];
      if (wr && hit_c) ctrl_c <= pwdata[7:0];
      if (wr && hit_div) baud_divisor <= pwdata[11:0];
      // a status write sets double speed and a one at the complete bit clears that flag; the empty bit is read-only
      if (wr && hit_st) double_speed_bit <= pwdata[st_double_speed_pos];
      // a data write fills the buffer and clears the empty flag; a write while full
      // replaces the pending character, so software polls the flag first
      if (data_wr) begin
        tx_buffer   <= mask_char({(char_size_field == char_size_nine) && tx_ninth_bit,
                                  pwdata[7:0]}, nbits);                        // RQ6 RQ9 RQ10 RQ11
        buffer_full <= 1'b1;                                                   // RQ15
      end else if (load_shift) begin
        buffer_full <= 1'b0;                                                   // RQ12
      end
      // set wins over ack or write-one clear
      if (frame_end && !buffer_full) begin
        tx_complete_flag <= 1'b1;                                              // RQ16
      end else if (complete_irq_ack ||
                   (wr && hit_st && pwdata[st_tx_complete_pos])) begin
        tx_complete_flag <= 1'b0;                                              // RQ17 RQ24
      end
    end
  end

  // read mux
  // reads have no side effects, so a polling loop is harmless
  always_comb begin
    prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (1'b1)
        hit_st:  prdata = {25'h0, tx_complete_flag, tx_buffer_empty_flag, 3'h0,
                           double_speed_bit, 1'b0};
        hit_b:   prdata = {24'h0, ctrl_b};
        hit_c:   prdata = {24'h0, ctrl_c};
        hit_div: prdata = {20'h0, baud_divisor};
        default: prdata = 32'h0000_0000;   // data register has no transmit read-back
      endcase
    end
  end

  // pins and interrupts
  // both interrupts are plain levels; the clock pin is driven only as sync master
  assign serial_out_pin       = drive_pin ? tx_line : port_out;               // RQ3
  assign serial_clock_pin_out = master_clk;
  assign serial_clock_pin_oe  = sync_mode && sync_master;                      // RQ4
  assign empty_irq            = tx_buffer_empty_irq_enable && tx_buffer_empty_flag;  // RQ14
  assign complete_irq         = complete_ie && tx_complete_flag;               // RQ24
endmodule

// ===== serial_line_model.sv
`timescale 1ns/1ps
// remote receiver: samples the line mid-bit at the bench's bit length
module serial_line_model (
  input  wire logic       sys_clk,
  input  wire logic       line,
  input  wire logic       armed,       // line is owned by the transmitter
  input  wire logic [5:0] bit_cycles,  // system clocks per bit
  input  wire logic [3:0] nbits,       // character length
  input  wire logic       par_en,
  input  wire logic       two_stop,
  output logic      [8:0] rx_data,     // character, lsb first on the wire
  output logic            rx_par,
  output logic      [1:0] rx_stop,     // stop samples, second only if asked
  output int              n_rx         // frames seen so far
);
  // start detection is a cycle late at worst, mid-bit sampling absorbs it
  initial begin
    n_rx = 0;
    forever begin
      @(posedge sys_clk);
      if (armed && !line) begin
        repeat (bit_cycles / 2) @(posedge sys_clk);
        rx_data = 9'h000;
        rx_par = 1'b0;
        rx_stop = 2'b00;
        for (int i = 0; i < nbits; i++) begin
          repeat (bit_cycles) @(posedge sys_clk);
          rx_data[i] = line;
        end
        if (par_en) begin
          repeat (bit_cycles) @(posedge sys_clk);
          rx_par = line;
        end
        repeat (bit_cycles) @(posedge sys_clk);
        rx_stop[0] = line;
        if (two_stop) begin
          repeat (bit_cycles) @(posedge sys_clk);
          rx_stop[1] = line;
        end
        n_rx++;
      end
    end
  end
endmodule

// ===== serial_tx_chk.sv
`timescale 1ns/1ps
module serial_tx_chk
  import serial_tx_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        port_out,
  input wire logic        serial_out_pin,
  input wire logic        serial_clock_pin_oe,
  input wire logic        empty_irq,
  input wire logic        complete_irq,
  input wire logic        complete_irq_ack
);
  logic [7:0] cb;       // shadow of control b
  logic [7:0] cc;       // shadow of control c
  logic       en_seen;  // transmitter enabled at least once
  wire acc    = psel && penable;
  wire wr     = acc && pwrite;
  wire mapped = paddr inside {status_off, ctrl_b_off, ctrl_c_off, data_off, divisor_off};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // shadows track apb writes at the same edge the design takes them
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cb      <= ctrl_b_rst;
      cc      <= ctrl_c_rst;
      en_seen <= 1'b0;
    end else if (wr && paddr == ctrl_b_off) begin
      cb      <= pwdata[7:0];
      en_seen <= en_seen | pwdata[cb_tx_enable_pos];
    end else if (wr && paddr == ctrl_c_off) begin
      cc <= pwdata[7:0];
    end
  end
  // a falling edge on the line in asynchronous mode
  sequence s_edge;
    en_seen && !cc[cc_sync_mode_pos] && $fell(serial_out_pin);
  endsequence
  property p_slverr; acc |-> pslverr == !mapped; endproperty
  property p_empty_mask; !cb[cb_empty_ie_pos] |-> !empty_irq; endproperty
  property p_cmp_mask; !cb[cb_complete_ie_pos] |-> !complete_irq; endproperty
  property p_data_clears; wr && paddr == data_off && cb[cb_empty_ie_pos] |=> !empty_irq; endproperty
  property p_ack; complete_irq_ack |=> !complete_irq; endproperty
  property p_w1c; wr && paddr == status_off && pwdata[st_tx_complete_pos] |=> !complete_irq; endproperty
  property p_oe; serial_clock_pin_oe |-> cc[cc_sync_mode_pos] && cc[cc_sync_master_pos]; endproperty
  property p_port; !en_seen && $stable(port_out) |-> serial_out_pin == port_out; endproperty
  property p_low_bit; s_edge |-> !serial_out_pin [*8]; endproperty
  property p_cmp_line; $rose(complete_irq) |-> serial_out_pin; endproperty
  a_slverr: assert property (p_slverr) else $error("slave error mismatch");
  a_empty_mask: assert property (p_empty_mask) else $error("empty irq while masked");
  a_cmp_mask: assert property (p_cmp_mask) else $error("complete irq while masked");
  a_data_clears: assert property (p_data_clears) else $error("empty irq after write");
  a_ack: assert property (p_ack) else $error("ack left complete set");
  a_w1c: assert property (p_w1c) else $error("write one left complete set");
  a_oe: assert property (p_oe) else $error("clock pin driven outside master");
  a_port: assert property (p_port) else $error("pin not port value");
  a_low_bit: assert property (p_low_bit) else $error("bit shorter than eight clocks");
  a_cmp_line: assert property (p_cmp_line) else $error("complete set mid frame");
endmodule

bind serial_tx serial_tx_chk u_chk (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pslverr, .port_out, .serial_out_pin, .serial_clock_pin_oe, .empty_irq,
  .complete_irq, .complete_irq_ack);

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import serial_tx_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, port_out, serial_out_pin, empty_irq, complete_irq;
  logic        clk_out, clk_oe;                // clock pin level and its enable
  logic        xck = 1'b0, xck_run = 1'b0;     // far-end clock for the sync slave test
  logic        complete_irq_ack = 1'b0;
  logic        armed = 1'b0;          // partner listens only once we drive
  logic [5:0]  bit_cycles = 6'h08;
  logic [3:0]  nbits = 4'h8;
  logic        par_en = 1'b0;
  logic        two_stop = 1'b0;
  logic [8:0]  rx_data;
  logic        rx_par;
  logic [1:0]  rx_stop;
  int          n_rx, n_errors = 0, checked = 0, cyc = 0;
  logic [31:0] rd;                    // last read data
  logic        er;                    // last error response
  int          exp_q[$];              // expected frames, parity at bit 9

  always #4 sys_clk = ~sys_clk;

  serial_tx dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port_out, .serial_out_pin, .serial_clock_pin_in(xck),
    .serial_clock_pin_out(clk_out), .serial_clock_pin_oe(clk_oe), .empty_irq, .complete_irq,
    .complete_irq_ack);
  serial_line_model remote (.sys_clk, .line(serial_out_pin), .armed, .bit_cycles, .nbits,
    .par_en, .two_stop, .rx_data, .rx_par, .rx_stop, .n_rx);

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; the answer is taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) n_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // hang guard, well above seven formats of two frames; also paces the slave clock
  always @(posedge sys_clk) begin
    cyc++;
    if (xck_run && cyc % 4 == 0) xck <= ~xck;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    logic [8:0] d;
    logic       odd, ds, ie_e, ie_c, c0;
    int         code, k, t;
    rd = $urandom(32'h1c3a7d04);
    port_out = rd[0];
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, ctrl_c_off, 0);
    chk("ctrl_c reset", ctrl_c_rst, rd);
    apb(1'b0, status_off, 0);
    chk("status reset", 32'h1 << st_buf_empty_pos, rd);
    chk("pin before enable", port_out, serial_out_pin);
    apb(1'b0, 8'h3c, 0);
    chk("unmapped error", 1, er);
    $display("test reset done");
    // sizes 5,6,7,8,9 with even, odd and no parity, one and two stops, then eight-bit
    // frames in sync master (polarity zero) and sync slave (polarity one), 8 clocks a bit
    for (int i = 0; i < 7; i++) begin
      code = (i == 4) ? 7 : ((i > 4) ? 3 : i);
      nbits = 4'((i == 4) ? 9 : ((i > 4) ? 8 : i + 5));
      par_en = (i != 2);
      odd = i[0];
      two_stop = (i == 2 || i == 4);
      ds = (i != 2 && i < 5);
      bit_cycles = 6'((i > 4) ? 8 : (ds ? 8 : 16) * ((i == 4) ? 2 : 1));
      ie_e = (i != 1);
      ie_c = (i != 3);
      xck_run <= (i == 6);
      apb(1'b1, divisor_off, (i == 4) ? 1 : ((i > 4) ? 3 : 0));
      apb(1'b1, status_off, ds << st_double_speed_pos);
      apb(1'b1, ctrl_c_off, ((i == 5) << 7) | ((i > 4) << 6) | (par_en << 5) | (odd << 4)
          | (two_stop << 3) | ((code & 3) << 1) | (i == 6));
      k = n_rx;
      for (int j = 0; j < 2; j++) begin
        d = 9'($urandom);
        d[8] = d[8] ^ j[0];
        apb(1'b1, ctrl_b_off, (ie_c << 6) | (ie_e << 5) | 8 | ((code >> 2) << 2) | d[8]);
        armed <= 1'b1;
        if (j == 0) chk("empty irq idle", ie_e, empty_irq);
        do apb(1'b0, status_off, 0); while (!rd[st_buf_empty_pos]);
        apb(1'b1, data_off, {23'h0, d});
        d = d & 9'((1 << nbits) - 1);
        exp_q.push_back({par_en & (^d ^ odd), d});
      end
      apb(1'b0, status_off, 0);
      chk("buffer held", 0, rd[st_buf_empty_pos]);
      for (int j = 0; j < 2; j++) begin
        for (t = 0; t < 4000 && n_rx == k; t++) @(posedge sys_clk);
        if (n_rx == k) n_errors++;   // no frame arrived in time
        k++;
        chk("frame", exp_q.pop_front(), {rx_par, rx_data});
        chk("stop bits", two_stop ? 3 : 1, rx_stop);
      end
      t = 0;
      do begin
        apb(1'b0, status_off, 0);
        t++;
      end while (!rd[st_tx_complete_pos] && t < 100);
      chk("status done", 32'h60 | (ds << 1), rd);
      chk("complete irq", ie_c, complete_irq);
      chk("empty irq done", ie_e, empty_irq);
      chk("clock pin enable", i == 5, clk_oe);
      if (i == 5) begin
        c0 = clk_out;
        repeat (4) @(posedge sys_clk);
        chk("master clock", !c0, clk_out);
      end
      if (odd) apb(1'b1, status_off, 32'h40 | (ds << 1));
      else begin
        complete_irq_ack <= 1'b1;
        @(posedge sys_clk);
        complete_irq_ack <= 1'b0;
        @(posedge sys_clk);
      end
      apb(1'b0, status_off, 0);
      chk("status cleared", 32'h20 | (ds << 1), rd);
      $display("test format %0d done", i);
    end
    print_verdict();
  end
endmodule
